// ===== common/pic_consts.vh
/*
 * Constants for the pulse input counter channels: pin offsets, mode
 * codes, edge multipliers, widths and the internal time base.
 * Assumes it is included by bare name from the design files.
 */
`ifndef PIC_CONSTS_VH
`define PIC_CONSTS_VH

// Channel count and widths
`define PIC_NCH 8
`define PIC_NPIN 8
`define PIC_CW 32
`define PIC_MODE_W 3
`define PIC_EDGE_W 2

// Pin offsets of the first group (even index) and second group
`define PIC_OFS_GRP0 0
`define PIC_OFS_GRP1 3
`define PIC_OFS_PH_A 0
`define PIC_OFS_PH_B 1
`define PIC_OFS_PRE 2
`define PIC_OFS_PRE_SW 1
`define PIC_OFS_EN_GRP0 6
`define PIC_OFS_EN_GRP1 7

// Counting modes
`define PIC_MODE_SW_DIR 3'h0
`define PIC_MODE_HW_DIR 3'h1
`define PIC_MODE_DUAL 3'h2
`define PIC_MODE_QUAD 3'h3
`define PIC_MODE_INT_CLK 3'h4

// Quadrature edge multipliers
`define PIC_EDGE_X1 2'h0
`define PIC_EDGE_X2 2'h1
`define PIC_EDGE_X4 2'h2

// Time base: system clock and internal count source in Hz
`define PIC_CLK_HZ 50000000
`define PIC_INT_HZ 1000000
`define PIC_INT_DIV (`PIC_CLK_HZ / `PIC_INT_HZ)
`define PIC_DIV_W 6

// Highest guaranteed external rates in kHz
`define PIC_QUAD_X1_KHZ 200
`define PIC_QUAD_X2_KHZ 100
`define PIC_QUAD_X4_KHZ 50
`define PIC_CTRL_PIN_KHZ 10

`endif

// ===== src/pic_chan_cnt.v
/*
 * One counter register of a pulse input channel.
 * Assumes up, down and load are one-cycle pulses made in ref_clk.
 */
`timescale 1ns/1ps
`include "pic_consts.vh"

module pic_chan_cnt (
   input wire ref_clk,
   input wire rst_n,
   input wire up,
   input wire down,
   input wire load,
   input wire [`PIC_CW-1:0] load_val,
   output reg [`PIC_CW-1:0] count_r
);

   reg [`PIC_CW-1:0] count_nxt;

   // Preset has priority; simultaneous up and down cancel out
   always @* begin
      count_nxt = count_r;
      if (load) begin
         count_nxt = load_val;
      end else if (up && !down) begin
         count_nxt = count_r + {{(`PIC_CW-1){1'b0}}, 1'b1};
      end else if (down && !up) begin
         count_nxt = count_r - {{(`PIC_CW-1){1'b0}}, 1'b1};
      end
   end

   // Counter state, wraps at the ends of the range
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= {`PIC_CW{1'b0}};
      end else begin
         count_r <= count_nxt;
      end
   end

endmodule

// ===== src/pic_counter_top.v
/*
 * Eight pulse input counter channels in two interleaved pin groups:
 * pin mapping, mode decode, edge detection and the 1 MHz time base.
 * Assumes pin inputs are synchronous to ref_clk and that the host
 * holds configuration stable while a channel is counting.
 */
// Contract
// - Even-index channels use pins 0 to 2 and enable pin 6, odd-index ones pins 3 to 5 and 7.
// - In hardware-direction mode the second pin selects up or down for pulses on the first.
// - Each channel has a bit that makes its external preset pin load the count or be ignored.
// - Each channel has a bit that makes its external enable pin gate counting or be ignored.
// - Quadrature mode counts one, two or four edges per input cycle as configured.
// - Internal-clock mode counts a fixed 1 MHz source and ignores every external pin.
`timescale 1ns/1ps
`include "pic_consts.vh"

module pic_counter_top (
   input wire ref_clk,
   input wire rst_n,
   input wire [`PIC_NPIN-1:0] pin_in,
   input wire [`PIC_NCH*`PIC_MODE_W-1:0] mode_cfg,
   input wire [`PIC_NCH*`PIC_EDGE_W-1:0] edge_cfg,
   input wire [`PIC_NCH-1:0] sw_down,
   input wire [`PIC_NCH-1:0] run_en,
   input wire [`PIC_NCH-1:0] preset_use,
   input wire [`PIC_NCH-1:0] enable_use,
   input wire [`PIC_NCH*`PIC_CW-1:0] preset_val,
   input wire [`PIC_NCH-1:0] sw_preset,
   output wire [`PIC_NCH*`PIC_CW-1:0] count,
   output reg [`PIC_NCH-1:0] count_up_r,
   output reg [`PIC_NCH-1:0] count_down_r
);

   // Divider end value, cut to the divider width on purpose
   localparam integer DIV_LAST_I = `PIC_INT_DIV - 1;
   localparam [`PIC_DIV_W-1:0] DIV_LAST = DIV_LAST_I[`PIC_DIV_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   // Pin history

   reg [`PIC_NPIN-1:0] pin_r;
   reg [`PIC_NPIN-1:0] pin_d_r;

   // Two stages: current and previous sample, compared for edges
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_r <= {`PIC_NPIN{1'b0}};
         pin_d_r <= {`PIC_NPIN{1'b0}};
      end else begin
         pin_r <= pin_in;
         pin_d_r <= pin_r;
      end
   end

   wire [`PIC_NPIN-1:0] pin_rise = pin_r & ~pin_d_r;
   wire [`PIC_NPIN-1:0] pin_fall = ~pin_r & pin_d_r;

   ////////////////////////////////////////////////////////////////////////
   // Internal 1 MHz time base

   reg [`PIC_DIV_W-1:0] div_r;
   reg tick_r;

   // Shared by all channels so internal-clock channels stay in step
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= {`PIC_DIV_W{1'b0}};
         tick_r <= 1'b0;
      end else if (div_r == DIV_LAST) begin
         div_r <= {`PIC_DIV_W{1'b0}};
         tick_r <= 1'b1;
      end else begin
         div_r <= div_r + {{(`PIC_DIV_W-1){1'b0}}, 1'b1};
         tick_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channels

   wire [`PIC_NCH-1:0] up_w;
   wire [`PIC_NCH-1:0] down_w;

   // Registered copies of the count events, for status or chaining
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_up_r <= {`PIC_NCH{1'b0}};
         count_down_r <= {`PIC_NCH{1'b0}};
      end else begin
         count_up_r <= up_w;
         count_down_r <= down_w;
      end
   end

   genvar k;
   generate
      for (k = 0; k < `PIC_NCH; k = k + 1) begin : g_ch
         // Group selects the pin block; all channels of one parity share pins
         localparam integer BASE = (k % 2 == 0) ? `PIC_OFS_GRP0 : `PIC_OFS_GRP1;
         localparam integer EN_PIN = (k % 2 == 0) ? `PIC_OFS_EN_GRP0 : `PIC_OFS_EN_GRP1;
         localparam integer PA = BASE + `PIC_OFS_PH_A;
         localparam integer PB = BASE + `PIC_OFS_PH_B;
         localparam integer PP = BASE + `PIC_OFS_PRE;
         localparam integer PP_SW = BASE + `PIC_OFS_PRE_SW;

         wire [`PIC_MODE_W-1:0] mode = mode_cfg[k*`PIC_MODE_W +: `PIC_MODE_W];
         wire [`PIC_EDGE_W-1:0] mult = edge_cfg[k*`PIC_EDGE_W +: `PIC_EDGE_W];
         wire is_int = (mode == `PIC_MODE_INT_CLK);
         wire is_sw = (mode == `PIC_MODE_SW_DIR);

         // Pin taps; in software-direction mode preset moves to the B slot
         wire a_lvl = pin_r[PA];
         wire b_lvl = pin_r[PB];
         wire a_up = pin_rise[PA];
         wire a_dn = pin_fall[PA];
         wire b_up = pin_rise[PB];
         wire b_dn = pin_fall[PB];
         wire pre_rise = is_sw ? pin_rise[PP_SW] : pin_rise[PP];
         wire en_lvl = pin_r[EN_PIN];

         // Enable pin gates only when selected; internal clock skips it
         wire gate = run_en[k] & (is_int | ~enable_use[k] | en_lvl);

         // External preset only when selected and not on internal clock
         wire ext_load = preset_use[k] & ~is_int & pre_rise;
         wire load = ext_load | sw_preset[k];

         // Quadrature decode: A leading B counts up
         reg q_up;
         reg q_dn;
         always @* begin
            q_up = 1'b0;
            q_dn = 1'b0;
            case (mult)
               `PIC_EDGE_X1: begin
                  q_up = a_up & ~b_lvl;
                  q_dn = a_up & b_lvl;
               end
               `PIC_EDGE_X2: begin
                  q_up = (a_up & ~b_lvl) | (a_dn & b_lvl);
                  q_dn = (a_up & b_lvl) | (a_dn & ~b_lvl);
               end
               `PIC_EDGE_X4: begin
                  q_up = (a_up & ~b_lvl) | (a_dn & b_lvl)
                     | (b_up & a_lvl) | (b_dn & ~a_lvl);
                  q_dn = (a_up & b_lvl) | (a_dn & ~b_lvl)
                     | (b_up & ~a_lvl) | (b_dn & a_lvl);
               end
               default: begin
                  q_up = 1'b0;
                  q_dn = 1'b0;
               end
            endcase
         end

         // Mode decode into raw up and down requests
         reg raw_up;
         reg raw_dn;
         always @* begin
            raw_up = 1'b0;
            raw_dn = 1'b0;
            case (mode)
               `PIC_MODE_SW_DIR: begin
                  raw_up = a_up & ~sw_down[k];
                  raw_dn = a_up & sw_down[k];
               end
               `PIC_MODE_HW_DIR: begin
                  // B is a level direction select, never counted itself
                  raw_up = a_up & ~b_lvl;
                  raw_dn = a_up & b_lvl;
               end
               `PIC_MODE_DUAL: begin
                  raw_up = a_up;
                  raw_dn = b_up;
               end
               `PIC_MODE_QUAD: begin
                  raw_up = q_up;
                  raw_dn = q_dn;
               end
               `PIC_MODE_INT_CLK: begin
                  raw_up = tick_r;
                  raw_dn = 1'b0;
               end
               default: begin
                  raw_up = 1'b0;
                  raw_dn = 1'b0;
               end
            endcase
         end

         // Preset wins over a count in the same cycle
         assign up_w[k] = raw_up & gate & ~load;
         assign down_w[k] = raw_dn & gate & ~load;

         pic_chan_cnt u_cnt (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .up(up_w[k]),
            .down(down_w[k]),
            .load(load),
            .load_val(preset_val[k*`PIC_CW +: `PIC_CW]),
            .count_r(count[k*`PIC_CW +: `PIC_CW])
         );
      end
   endgenerate

   // Preset and enable pins are sampled every cycle; the slow toggle
   // limit on them only bounds how often the host sees a change.

endmodule

// ===== dv/pic_chk_sva.sv
/* Port checker for pic_counter_top, channels 0 and 1.
   Assumes config is held steady around each pin event. */
`timescale 1ns/1ps
`include "pic_consts.vh"
module pic_chk (
   input wire ref_clk,
   input wire rst_n,
   input wire [7:0] pin_in,
   input wire [23:0] mode_cfg,
   input wire [15:0] edge_cfg,
   input wire [7:0] run_en,
   input wire [7:0] preset_use,
   input wire [7:0] enable_use,
   input wire [255:0] preset_val,
   input wire [7:0] sw_preset,
   input wire [255:0] count,
   input wire [7:0] count_up_r,
   input wire [7:0] count_down_r
);
   wire [2:0] m0 = mode_cfg[2:0];
   wire ok0 = run_en[0] & ~enable_use[0] & ~preset_use[0] & ~sw_preset[0];
   wire ev0 = count_up_r[0] | count_down_r[0];
   reg [5:0] gap_r;
   reg int_r;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_quiet;
      !ev0;
   endsequence
   ////////////////////////////////////////
   // Gap between ticks; armed only by a tick seen in steady internal mode
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_r <= 6'h00;
         int_r <= 1'b0;
      end else begin
         gap_r <= count_up_r[0] ? 6'h00 : gap_r + 6'h01;
         int_r <= (m0 == 3'h4) & run_en[0] & ~sw_preset[0] & (int_r | count_up_r[0]);
      end
   end
   // Event outputs are seen two clocks after the pin edge is sampled
   a_map_odd: assert property ($rose(pin_in[3]) ##1 (mode_cfg[5:3] == 3'h2 &&
      run_en[1] && !enable_use[1] && !preset_use[1] && !sw_preset[1]) |=> count_up_r[1])
      else $error("odd channel missed its A pulse");
   a_hw_dir: assert property (($rose(pin_in[1]) && $stable(pin_in[0])) ##1
      (m0 == 3'h1 && ok0) |=> s_quiet) else $error("direction pin counted");
   a_preset_pin: assert property ($rose(pin_in[2]) ##1 (preset_use[0] && m0 == 3'h2)
      |=> count[31:0] == $past(preset_val[31:0])) else $error("preset pin did not load");
   a_en_gate: assert property (!pin_in[6] ##1 (enable_use[0] && m0 != 3'h4 && run_en[0])
      |=> s_quiet) else $error("counted with enable low");
   a_quad_x1: assert property (($rose(pin_in[0]) && !pin_in[1]) ##1 (m0 == 3'h3 &&
      edge_cfg[1:0] == 2'h0 && ok0) |=> count_up_r[0] && !count_down_r[0])
      else $error("quadrature rise missed");
   a_int_rate: assert property (count_up_r[0] && int_r |-> gap_r == `PIC_INT_DIV - 1)
      else $error("internal tick spacing wrong");
   a_dual_dn: assert property (($rose(pin_in[1]) && $stable(pin_in[0])) ##1
      (m0 == 3'h2 && ok0) |=> count_down_r[0] && !count_up_r[0])
      else $error("B pulse did not count down");
endmodule
bind pic_counter_top pic_chk i_chk (.ref_clk, .rst_n, .pin_in, .mode_cfg, .edge_cfg,
   .run_en, .preset_use, .enable_use, .preset_val, .sw_preset, .count, .count_up_r,
   .count_down_r);

// ===== dv/pic_src.sv
/* Pulse source model driving the eight input pins.
   Assumes the bench asks for patterns on ref_clk edges. */
`timescale 1ns/1ps
module pic_src (
   input wire ref_clk,
   input wire [7:0] want,
   output reg [7:0] pin_out
);
   // Pins follow the request a clock late; preset and enable move a few times a test
   initial pin_out = 8'h00;
   always @(posedge ref_clk) pin_out <= want;
endmodule

// ===== dv/pic_counter_top_bench.sv
/* Self-checking bench for pic_counter_top.
   Assumes pic_src feeds the pins and pic_chk is bound. */
`timescale 1ns/1ps
`include "pic_consts.vh"
module pic_counter_top_bench;
   reg ref_clk, rst_n;
   reg [7:0] want, run_en, preset_use, enable_use, sw_down, sw_preset;
   reg [23:0] mode_cfg;
   reg [15:0] edge_cfg;
   wire [7:0] pin_in, count_up_r, count_down_r;
   wire [255:0] count;
   integer errors, tests_run, k;
   reg [31:0] base;
   reg [21:0] rows [0:10];
   pic_src i_pic_src (.ref_clk(ref_clk), .want(want), .pin_out(pin_in));
   pic_counter_top i_pic_counter_top (.ref_clk(ref_clk), .rst_n(rst_n), .pin_in(pin_in),
      .mode_cfg(mode_cfg), .edge_cfg(edge_cfg), .sw_down(sw_down), .run_en(run_en),
      .preset_use(preset_use), .enable_use(enable_use), .preset_val({8{32'h00000064}}),
      .sw_preset(sw_preset), .count(count), .count_up_r(count_up_r),
      .count_down_r(count_down_r));
   ////////////////////////////////////////
   // 50 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // Four two-bit steps shifted onto a pin group, each held 4 clocks
   task run(input [7:0] s, input [2:0] sh, input [7:0] hold);
      integer j;
      begin
         @(posedge ref_clk);
         for (j = 0; j < 4; j = j + 1) begin
            want <= ({6'h00, s[2*j +: 2]} << sh) | hold;
            repeat (4) @(posedge ref_clk);
         end
         want <= 8'h00;
         repeat (4) @(posedge ref_clk);
         #1;
      end
   endtask
   // Load the preset of 100 into every channel
   task load;
      begin
         @(posedge ref_clk);
         sw_preset <= 8'hff;
         @(posedge ref_clk);
         sw_preset <= 8'h00;
         repeat (3) @(posedge ref_clk);
      end
   endtask
   task results;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, errors);
         if (errors == 0 && tests_run > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   // Rows: mode, edge, sw_down, pin steps, expected signed change
   initial begin
      errors = 0;
      tests_run = 0;
      rst_n = 1'b0;
      want = 8'h00;
      run_en = 8'hff;
      preset_use = 8'h00;
      enable_use = 8'h00;
      sw_down = 8'h00;
      sw_preset = 8'h00;
      mode_cfg = 24'h000000;
      edge_cfg = 16'h0000;
      rows = '{{3'h0, 2'h0, 1'b0, 8'h11, 8'h02}, {3'h0, 2'h0, 1'b1, 8'h11, 8'hfe},
         {3'h1, 2'h0, 1'b0, 8'h22, 8'h00}, {3'h2, 2'h0, 1'b0, 8'h11, 8'h02},
         {3'h2, 2'h0, 1'b0, 8'h22, 8'hfe}, {3'h3, 2'h0, 1'b0, 8'h2d, 8'h01},
         {3'h3, 2'h1, 1'b0, 8'h2d, 8'h02}, {3'h3, 2'h2, 1'b0, 8'h2d, 8'h04},
         {3'h3, 2'h2, 1'b0, 8'h1e, 8'hfc}, {3'h3, 2'h3, 1'b0, 8'h2d, 8'h00},
         {3'h5, 2'h0, 1'b0, 8'h11, 8'h00}};
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      for (k = 0; k < 11; k = k + 1) begin
         @(posedge ref_clk);
         mode_cfg <= {8{rows[k][21:19]}};
         edge_cfg <= {8{rows[k][18:17]}};
         sw_down <= {8{rows[k][16]}};
         load;
         run(rows[k][15:8], 3'h0, 8'h00);
         chk(count[31:0], 32'h64 + {{24{rows[k][7]}}, rows[k][7:0]});
         chk(count[63:32], 32'h64);
         $display("row %0d done", k);
      end
      // Level of B picks opposite senses for A pulses
      @(posedge ref_clk);
      mode_cfg <= {8{3'h1}};
      load;
      run(8'h11, 3'h0, 8'h00);
      base = count[31:0];
      load;
      run(8'hbb, 3'h0, 8'h00);
      chk(count[31:0], 32'h62);
      chk(base, 32'h66);
      $display("direction test done");
      // Odd group uses pins 3 to 5 and enable 7; enable pin gates counting
      @(posedge ref_clk);
      mode_cfg <= {8{3'h2}};
      enable_use <= 8'h01;
      load;
      run(8'h11, 3'h3, 8'h80);
      chk(count[63:32], 32'h66);
      @(posedge ref_clk);
      enable_use <= 8'h03;
      load;
      run(8'h11, 3'h3, 8'h40);
      chk(count[63:32], 32'h64);
      load;
      run(8'h11, 3'h0, 8'h00);
      chk(count[31:0], 32'h64);
      chk(count[95:64], 32'h66);
      load;
      run(8'h11, 3'h0, 8'h40);
      chk(count[31:0], 32'h66);
      $display("enable test done");
      // Preset pin loads only where its use bit is set
      @(posedge ref_clk);
      enable_use <= 8'h00;
      load;
      run(8'h11, 3'h0, 8'h00);
      @(posedge ref_clk);
      preset_use <= 8'h01;
      run(8'h00, 3'h0, 8'h04);
      chk(count[31:0], 32'h64);
      chk(count[95:64], 32'h66);
      // Software-direction mode moves the preset to the B slot
      @(posedge ref_clk);
      mode_cfg <= {8{3'h0}};
      run(8'h11, 3'h0, 8'h00);
      run(8'h00, 3'h0, 8'h04);
      chk(count[31:0], 32'h66);
      run(8'h02, 3'h0, 8'h00);
      chk(count[31:0], 32'h64);
      $display("preset test done");
      // Internal clock ignores every pin: 10 ticks in 500 clocks
      @(posedge ref_clk);
      mode_cfg <= {8{3'h4}};
      preset_use <= 8'hff;
      enable_use <= 8'hff;
      repeat (60) @(posedge ref_clk);
      #1;
      base = count[31:0];
      run(8'h11, 3'h0, 8'h04);
      repeat (479) @(posedge ref_clk);
      #1;
      chk(count[31:0] - base, 500 / `PIC_INT_DIV);
      $display("internal clock test done");
      // Reset in mid-run clears counts and event outputs
      @(posedge ref_clk);
      rst_n <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk(count[31:0], 32'h0);
      chk(count_up_r, 32'h0);
      // Time base restarts: first tick lands 51 clocks after release
      @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (50) @(posedge ref_clk);
      #1;
      chk(count[31:0], 32'h0);
      @(posedge ref_clk);
      #1;
      chk(count[31:0], 32'h1);
      chk(count_up_r, 32'hff);
      $display("reset test done");
      results;
   end
endmodule
